// file: common/pmx_pkg.sv
package pmx_pkg;

    // =========================================================
    // pin counts and function codes
    localparam int PMX_PF_PINS = 16;
    localparam int PMX_PG_PINS = 16;
    localparam int PMX_PH_PINS = 8;
    localparam int PMX_ALTS = 4;
    localparam int PMX_DBUS_W = 16;

    typedef enum logic [2:0] {
        PMX_FN_GPIO = 3'h0,
        PMX_FN_ALT0 = 3'h1,
        PMX_FN_ALT1 = 3'h2,
        PMX_FN_ALT2 = 3'h3,
        PMX_FN_ALT3 = 3'h4
    } pmx_func_t;

    // =========================================================
    // fixed alternate slots of routed memory and video signals
    localparam int PMX_PPI_SLOT = 1;
    localparam int PMX_AMS2_PIN = 11;
    localparam int PMX_AMS2_SLOT = 1;
    localparam int PMX_AMS3_PIN = 15;
    localparam int PMX_AMS3_SLOT = 2;
    localparam int PMX_AOE_PIN = 4;
    localparam int PMX_AOE_SLOT = 1;
    localparam int PMX_ASYNC_READY_INPUT_PIN = 5;
    localparam int PMX_ASYNC_READY_INPUT_SLOT = 1;

    // =========================================================
    // i2c drive type field
    localparam logic [2:0] PMX_I2C_DT_RESET = 3'h0;
    localparam logic [2:0] PMX_I2C_DT_MAX = 3'h6;

    // =========================================================
    // carriers
    typedef struct packed {
        pmx_func_t func;
        logic gpio_out;
        logic gpio_dir;
        logic gpio_ien;
    } pmx_pin_cfg_t;

    typedef struct packed {
        logic [PMX_ALTS-1:0] out;
        logic [PMX_ALTS-1:0] oe;
    } pmx_pin_alt_t;

    typedef struct packed {
        logic [19:1] addr;
        logic [1:0] byte_en;
        logic [1:0] bank_sel;
        logic rd_en;
        logic wr_en;
        logic row_strobe;
        logic col_strobe;
        logic sd_wr_en;
        logic sd_clk_en;
        logic sd_addr10;
        logic sd_bank_sel;
    } pmx_emi_t;

    localparam pmx_emi_t PMX_EMI_RESET = '1;

    // =========================================================
    // state records
    typedef struct packed {
        logic out;
        logic oe;
        logic sync1;
        logic sync2;
    } pmx_cell_state_t;

    localparam pmx_cell_state_t PMX_CELL_RESET = '0;

    typedef struct packed {
        pmx_emi_t emi;
        logic emi_oe;
        logic [PMX_DBUS_W-1:0] dbus_out;
        logic dbus_oe;
        logic [PMX_DBUS_W-1:0] dbus_s1;
        logic [PMX_DBUS_W-1:0] dbus_s2;
        logic sda_oe;
        logic scl_oe;
        logic sda_s1;
        logic sda_s2;
        logic scl_s1;
        logic scl_s2;
        logic [2:0] drive_type;
    } pmx_top_state_t;

endpackage : pmx_pkg

// file: core/pmx_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module pmx_pin_cell
    import pmx_pkg::*;
#(
    parameter logic PULL_EXEMPT = 1'b0,
    parameter logic [PMX_ALTS-1:0] ALT_IDLE = 4'h0
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic hibernate,
    input wire pmx_pin_cfg_t cfg,
    input wire pmx_pin_alt_t alt,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic gpio_in,
    output logic [PMX_ALTS-1:0] alt_in
);

    pmx_cell_state_t st_reg;
    pmx_cell_state_t st_next;
    logic buf_on;

    // =========================================================
    // function select, one driver per pin
    always_comb
    begin
        st_next = st_reg;
        st_next.sync1 = pad_in;
        st_next.sync2 = st_reg.sync1;
        buf_on = PULL_EXEMPT;
        unique case (cfg.func)
            PMX_FN_ALT0:
            begin
                st_next.out = alt.out[0];
                st_next.oe = alt.oe[0];
                buf_on = 1'b1;
            end
            PMX_FN_ALT1:
            begin
                st_next.out = alt.out[1];
                st_next.oe = alt.oe[1];
                buf_on = 1'b1;
            end
            PMX_FN_ALT2:
            begin
                st_next.out = alt.out[2];
                st_next.oe = alt.oe[2];
                buf_on = 1'b1;
            end
            PMX_FN_ALT3:
            begin
                st_next.out = alt.out[3];
                st_next.oe = alt.oe[3];
                buf_on = 1'b1;
            end
            default:
            begin
                st_next.out = cfg.gpio_out;
                st_next.oe = cfg.gpio_dir;
                buf_on = PULL_EXEMPT | cfg.gpio_ien;
            end
        endcase
        if (hibernate)
        begin
            st_next.oe = 1'b0;
        end
    end

    // =========================================================
    // input steering, deselected inputs idle
    always_comb
    begin
        gpio_in = 1'b0;
        if (cfg.func == PMX_FN_GPIO || cfg.func > PMX_FN_ALT3)
        begin
            gpio_in = st_reg.sync2 & buf_on;
        end
        for (int k = 0; k < PMX_ALTS; k++)
        begin
            alt_in[k] = ALT_IDLE[k];
            if (cfg.func == pmx_func_t'(3'(k + 1)))
            begin
                alt_in[k] = st_reg.sync2;
            end
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            st_reg <= PMX_CELL_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign pad_out = st_reg.out;
    assign pad_oe = st_reg.oe;

endmodule : pmx_pin_cell

`default_nettype wire

// file: core/pmx_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none

module pmx_pin_mux
    import pmx_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic hibernate,
    // crystal buffer
    input wire logic xtal_in,
    output logic crystal_buffer_out,
    // sdram clock
    output logic sdram_clock_out,
    output logic sdram_clock_out_oe,
    // memory controller side
    input wire pmx_emi_t emi_ctrl,
    input wire logic [PMX_DBUS_W-1:0] ext_data_wr,
    input wire logic ext_data_wr_en,
    output logic [PMX_DBUS_W-1:0] ext_data_rd,
    input wire logic [1:0] async_bank_select_hi,
    input wire logic async_output_enable,
    output logic async_ready_input,
    // memory pins
    output pmx_emi_t emi_pins,
    output logic emi_pins_oe,
    input wire logic [PMX_DBUS_W-1:0] ext_data_bus_in,
    output logic [PMX_DBUS_W-1:0] ext_data_bus_out,
    output logic ext_data_bus_oe,
    // parallel video port data
    input wire logic [PMX_PF_PINS-1:0] ppi_data_out,
    input wire logic [PMX_PF_PINS-1:0] ppi_data_oe,
    output logic [PMX_PF_PINS-1:0] ppi_data_in,
    // port f
    input wire pmx_pin_cfg_t [PMX_PF_PINS-1:0] portf_cfg,
    input wire pmx_pin_alt_t [PMX_PF_PINS-1:0] portf_alt,
    output logic [PMX_PF_PINS-1:0][PMX_ALTS-1:0] portf_alt_in,
    output logic [PMX_PF_PINS-1:0] portf_gpio_in,
    input wire logic [PMX_PF_PINS-1:0] portf_pad_in,
    output logic [PMX_PF_PINS-1:0] portf_pad_out,
    output logic [PMX_PF_PINS-1:0] portf_pad_oe,
    // port g
    input wire pmx_pin_cfg_t [PMX_PG_PINS-1:0] portg_cfg,
    input wire pmx_pin_alt_t [PMX_PG_PINS-1:0] portg_alt,
    output logic [PMX_PG_PINS-1:0][PMX_ALTS-1:0] portg_alt_in,
    output logic [PMX_PG_PINS-1:0] portg_gpio_in,
    input wire logic [PMX_PG_PINS-1:0] portg_pad_in,
    output logic [PMX_PG_PINS-1:0] portg_pad_out,
    output logic [PMX_PG_PINS-1:0] portg_pad_oe,
    // port h
    input wire pmx_pin_cfg_t [PMX_PH_PINS-1:0] porth_cfg,
    input wire pmx_pin_alt_t [PMX_PH_PINS-1:0] porth_alt,
    output logic [PMX_PH_PINS-1:0][PMX_ALTS-1:0] porth_alt_in,
    output logic [PMX_PH_PINS-1:0] porth_gpio_in,
    input wire logic [PMX_PH_PINS-1:0] porth_pad_in,
    output logic [PMX_PH_PINS-1:0] porth_pad_out,
    output logic [PMX_PH_PINS-1:0] porth_pad_oe,
    // i2c open drain pins
    input wire logic i2c_sda_pull_low,
    input wire logic i2c_scl_pull_low,
    input wire logic i2c_sda_pad_in,
    input wire logic i2c_scl_pad_in,
    output logic i2c_sda_pad_out,
    output logic i2c_sda_pad_oe,
    output logic i2c_scl_pad_out,
    output logic i2c_scl_pad_oe,
    output logic i2c_sda_in,
    output logic i2c_scl_in,
    // i2c drive type
    input wire logic [2:0] i2c_drive_type_sel,
    output logic [2:0] i2c_drive_type
);

    pmx_top_state_t st_reg;
    pmx_top_state_t st_next;
    pmx_top_state_t st_reset;

    pmx_pin_alt_t [PMX_PF_PINS-1:0] pf_alt;
    pmx_pin_alt_t [PMX_PG_PINS-1:0] pg_alt;
    pmx_pin_alt_t [PMX_PH_PINS-1:0] ph_alt;
    logic [PMX_PF_PINS-1:0][PMX_ALTS-1:0] pf_in;
    logic [PMX_PH_PINS-1:0][PMX_ALTS-1:0] ph_in;

    // =========================================================
    // reset image of the memory and i2c state
    always_comb
    begin
        st_reset = '0;
        st_reset.emi = PMX_EMI_RESET;
        st_reset.emi_oe = 1'b1;
        st_reset.drive_type = PMX_I2C_DT_RESET;
    end

    // =========================================================
    // next state of memory pins, data bus and i2c
    always_comb
    begin
        st_next = st_reg;
        st_next.emi = emi_ctrl;
        st_next.emi_oe = ~hibernate;
        st_next.dbus_out = ext_data_wr;
        st_next.dbus_oe = ext_data_wr_en & ~hibernate;
        st_next.dbus_s1 = ext_data_bus_in;
        st_next.dbus_s2 = st_reg.dbus_s1;
        st_next.sda_oe = i2c_sda_pull_low & ~hibernate;
        st_next.scl_oe = i2c_scl_pull_low & ~hibernate;
        st_next.sda_s1 = i2c_sda_pad_in;
        st_next.sda_s2 = st_reg.sda_s1;
        st_next.scl_s1 = i2c_scl_pad_in;
        st_next.scl_s2 = st_reg.scl_s1;
        if (i2c_drive_type_sel <= PMX_I2C_DT_MAX)
        begin
            st_next.drive_type = i2c_drive_type_sel;
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            st_reg <= st_reset;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // memory, clock and i2c pin outputs
    // clock forwarded
    assign sdram_clock_out = mclk;
    assign sdram_clock_out_oe = st_reg.emi_oe;
    assign crystal_buffer_out = xtal_in;
    assign emi_pins = st_reg.emi;
    assign emi_pins_oe = st_reg.emi_oe;
    assign ext_data_bus_out = st_reg.dbus_out;
    assign ext_data_bus_oe = st_reg.dbus_oe;
    assign ext_data_rd = st_reg.dbus_s2;
    assign i2c_sda_pad_out = 1'b0;
    assign i2c_scl_pad_out = 1'b0;
    assign i2c_sda_pad_oe = st_reg.sda_oe;
    assign i2c_scl_pad_oe = st_reg.scl_oe;
    assign i2c_sda_in = st_reg.sda_s2;
    assign i2c_scl_in = st_reg.scl_s2;
    assign i2c_drive_type = st_reg.drive_type;

    // =========================================================
    // port f alternates, video data in its fixed slot
    always_comb
    begin
        pf_alt = portf_alt;
        portf_alt_in = pf_in;
        for (int n = 0; n < PMX_PF_PINS; n++)
        begin
            pf_alt[n].out[PMX_PPI_SLOT] = ppi_data_out[n];
            pf_alt[n].oe[PMX_PPI_SLOT] = ppi_data_oe[n];
            ppi_data_in[n] = pf_in[n][PMX_PPI_SLOT];
            portf_alt_in[n][PMX_PPI_SLOT] = 1'b0;
        end
    end

    // =========================================================
    // port g alternates, upper async bank selects
    always_comb
    begin
        pg_alt = portg_alt;
        pg_alt[PMX_AMS2_PIN].out[PMX_AMS2_SLOT] = async_bank_select_hi[0];
        pg_alt[PMX_AMS2_PIN].oe[PMX_AMS2_SLOT] = 1'b1;
        pg_alt[PMX_AMS3_PIN].out[PMX_AMS3_SLOT] = async_bank_select_hi[1];
        pg_alt[PMX_AMS3_PIN].oe[PMX_AMS3_SLOT] = 1'b1;
    end

    // =========================================================
    // port h alternates, async output enable and ready
    always_comb
    begin
        ph_alt = porth_alt;
        porth_alt_in = ph_in;
        ph_alt[PMX_AOE_PIN].out[PMX_AOE_SLOT] = async_output_enable;
        ph_alt[PMX_AOE_PIN].oe[PMX_AOE_SLOT] = 1'b1;
        ph_alt[PMX_ASYNC_READY_INPUT_PIN].oe[PMX_ASYNC_READY_INPUT_SLOT] = 1'b0;
        ph_alt[PMX_ASYNC_READY_INPUT_PIN].out[PMX_ASYNC_READY_INPUT_SLOT] = 1'b0;
        async_ready_input = ph_in[PMX_ASYNC_READY_INPUT_PIN][PMX_ASYNC_READY_INPUT_SLOT];
        porth_alt_in[PMX_ASYNC_READY_INPUT_PIN][PMX_ASYNC_READY_INPUT_SLOT] = 1'b0;
    end

    // =========================================================
    // port f pin cells
    // port f cells
    for (genvar i = 0; i < PMX_PF_PINS; i++)
    begin : g_pf
        pmx_pin_cell u_cell (
            .mclk(mclk),
            .resetn(resetn),
            .hibernate(hibernate),
            .cfg(portf_cfg[i]),
            .alt(pf_alt[i]),
            .pad_in(portf_pad_in[i]),
            .pad_out(portf_pad_out[i]),
            .pad_oe(portf_pad_oe[i]),
            .gpio_in(portf_gpio_in[i]),
            .alt_in(pf_in[i])
        );
    end

    // =========================================================
    // port g pin cells
    // port g cells
    for (genvar i = 0; i < PMX_PG_PINS; i++)
    begin : g_pg
        pmx_pin_cell u_cell (
            .mclk(mclk),
            .resetn(resetn),
            .hibernate(hibernate),
            .cfg(portg_cfg[i]),
            .alt(pg_alt[i]),
            .pad_in(portg_pad_in[i]),
            .pad_out(portg_pad_out[i]),
            .pad_oe(portg_pad_oe[i]),
            .gpio_in(portg_gpio_in[i]),
            .alt_in(portg_alt_in[i])
        );
    end

    // =========================================================
    // port h pin cells
    // port h cells
    for (genvar i = 0; i < PMX_PH_PINS; i++)
    begin : g_ph
        pmx_pin_cell u_cell (
            .mclk(mclk),
            .resetn(resetn),
            .hibernate(hibernate),
            .cfg(porth_cfg[i]),
            .alt(ph_alt[i]),
            .pad_in(porth_pad_in[i]),
            .pad_out(porth_pad_out[i]),
            .pad_oe(porth_pad_oe[i]),
            .gpio_in(porth_gpio_in[i]),
            .alt_in(ph_in[i])
        );
    end

endmodule : pmx_pin_mux

`default_nettype wire

// file: testbench/pmx_checker.sv
`timescale 1ns/1ps
`default_nettype none

module pmx_checker
    import pmx_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic hibernate,
    input wire pmx_emi_t emi_ctrl,
    input wire pmx_emi_t emi_pins,
    input wire logic emi_pins_oe,
    input wire logic ext_data_bus_oe,
    input wire logic [PMX_PF_PINS-1:0] portf_pad_oe,
    input wire logic [PMX_PG_PINS-1:0] portg_pad_oe,
    input wire logic sdram_clock_out_oe,
    input wire logic i2c_sda_pull_low,
    input wire logic i2c_sda_pad_out,
    input wire logic i2c_sda_pad_oe,
    input wire logic [2:0] i2c_drive_type_sel,
    input wire logic [2:0] i2c_drive_type
);
    // =========================================================
    // pin rules
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    rst_pins_a: assert property ($rose(resetn) |-> emi_pins == PMX_EMI_RESET && emi_pins_oe
        && !ext_data_bus_oe && portf_pad_oe == '0) else $error("reset pin state wrong");
    clk_drive_a: assert property ($rose(resetn) |-> sdram_clock_out_oe)
        else $error("sdram clock not driven after reset");
    emi_follow_a: assert property ($past(resetn) |-> emi_pins == $past(emi_ctrl))
        else $error("memory pins do not follow controller");
    hib_tristate_a: assert property (hibernate |=> !emi_pins_oe && !sdram_clock_out_oe
        && portg_pad_oe == '0 && !i2c_sda_pad_oe) else $error("output driven in hibernate");
    sda_low_a: assert property (i2c_sda_pad_out == 1'b0)
        else $error("i2c pin driven high");
    sda_pull_a: assert property (!hibernate |=> i2c_sda_pad_oe == $past(i2c_sda_pull_low))
        else $error("i2c pull does not follow request");
    dt_hold_a: assert property (i2c_drive_type_sel == 3'h7 |=> $stable(i2c_drive_type))
        else $error("reserved drive type taken");
    dt_load_a: assert property (i2c_drive_type_sel <= PMX_I2C_DT_MAX
        |=> i2c_drive_type == $past(i2c_drive_type_sel)) else $error("drive type not loaded");
    dt_reset_a: assert property ($rose(resetn) |-> i2c_drive_type == PMX_I2C_DT_RESET)
        else $error("drive type reset wrong");
endmodule : pmx_checker

bind pmx_pin_mux pmx_checker chk_u (.mclk(mclk), .resetn(resetn), .hibernate(hibernate),
    .emi_ctrl(emi_ctrl), .emi_pins(emi_pins), .emi_pins_oe(emi_pins_oe), .ext_data_bus_oe(ext_data_bus_oe),
    .portf_pad_oe(portf_pad_oe), .portg_pad_oe(portg_pad_oe), .sdram_clock_out_oe(sdram_clock_out_oe),
    .i2c_sda_pull_low(i2c_sda_pull_low), .i2c_sda_pad_out(i2c_sda_pad_out), .i2c_sda_pad_oe(i2c_sda_pad_oe),
    .i2c_drive_type_sel(i2c_drive_type_sel), .i2c_drive_type(i2c_drive_type));

`default_nettype wire

// file: testbench/pmx_board_model.sv
`timescale 1ns/1ps
`default_nettype none

// =========================================================
// board side of a group of pads
module pmx_board_model #(
    parameter int W = 16
)
(
    input wire logic mclk,
    input wire logic [W-1:0] pad_out,
    input wire logic [W-1:0] pad_oe,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pad_in
);
    logic [W-1:0] last_reg = '0;

    // floating lines show the inverse of the last level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & ~last_reg);

    // remember the level of each line
    always_ff @(posedge mclk)
    begin
        last_reg <= pad_in;
    end
endmodule : pmx_board_model

`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import pmx_pkg::*;
    logic mclk, resetn, hibernate, xtal_in, crystal_buffer_out, sdram_clock_out, sdram_clock_out_oe;
    logic ext_data_wr_en, async_output_enable, async_ready_input, emi_pins_oe, ext_data_bus_oe;
    logic i2c_sda_pull_low, i2c_scl_pull_low, i2c_sda_pad_in, i2c_scl_pad_in, i2c_sda_pad_out, i2c_sda_pad_oe;
    logic i2c_scl_pad_out, i2c_scl_pad_oe, i2c_sda_in, i2c_scl_in;
    logic [1:0] async_bank_select_hi;
    logic [2:0] i2c_drive_type_sel, i2c_drive_type;
    logic [15:0] ext_data_wr, ext_data_rd, ext_data_bus_in, ext_data_bus_out, ppi_data_out, ppi_data_oe;
    logic [15:0] ppi_data_in, portf_gpio_in, portf_pad_in, portf_pad_out, portf_pad_oe, portg_gpio_in;
    logic [15:0] portg_pad_in, portg_pad_out, portg_pad_oe, fv, fe, gv, ge, dv, de;
    logic [7:0] porth_gpio_in, porth_pad_in, porth_pad_out, porth_pad_oe, hv, he;
    logic [15:0][3:0] portf_alt_in, portg_alt_in;
    logic [7:0][3:0] porth_alt_in;
    pmx_emi_t emi_ctrl, emi_pins;
    pmx_pin_cfg_t [15:0] portf_cfg, portg_cfg;
    pmx_pin_cfg_t [7:0] porth_cfg;
    pmx_pin_alt_t [15:0] portf_alt, portg_alt;
    pmx_pin_alt_t [7:0] porth_alt;
    int bad_count = 0;
    int n_compared = 0;

    pmx_pin_mux dut_u (.mclk(mclk), .resetn(resetn), .hibernate(hibernate), .xtal_in(xtal_in),
        .crystal_buffer_out(crystal_buffer_out), .sdram_clock_out(sdram_clock_out),
        .sdram_clock_out_oe(sdram_clock_out_oe), .emi_ctrl(emi_ctrl), .ext_data_wr(ext_data_wr),
        .ext_data_wr_en(ext_data_wr_en), .ext_data_rd(ext_data_rd), .async_bank_select_hi(async_bank_select_hi),
        .async_output_enable(async_output_enable), .async_ready_input(async_ready_input), .emi_pins(emi_pins),
        .emi_pins_oe(emi_pins_oe), .ext_data_bus_in(ext_data_bus_in), .ext_data_bus_out(ext_data_bus_out),
        .ext_data_bus_oe(ext_data_bus_oe), .ppi_data_out(ppi_data_out), .ppi_data_oe(ppi_data_oe),
        .ppi_data_in(ppi_data_in), .portf_cfg(portf_cfg), .portf_alt(portf_alt), .portf_alt_in(portf_alt_in),
        .portf_gpio_in(portf_gpio_in), .portf_pad_in(portf_pad_in), .portf_pad_out(portf_pad_out),
        .portf_pad_oe(portf_pad_oe), .portg_cfg(portg_cfg), .portg_alt(portg_alt), .portg_alt_in(portg_alt_in),
        .portg_gpio_in(portg_gpio_in), .portg_pad_in(portg_pad_in), .portg_pad_out(portg_pad_out),
        .portg_pad_oe(portg_pad_oe), .porth_cfg(porth_cfg), .porth_alt(porth_alt), .porth_alt_in(porth_alt_in),
        .porth_gpio_in(porth_gpio_in), .porth_pad_in(porth_pad_in), .porth_pad_out(porth_pad_out),
        .porth_pad_oe(porth_pad_oe), .i2c_sda_pull_low(i2c_sda_pull_low), .i2c_scl_pull_low(i2c_scl_pull_low),
        .i2c_sda_pad_in(i2c_sda_pad_in), .i2c_scl_pad_in(i2c_scl_pad_in), .i2c_sda_pad_out(i2c_sda_pad_out),
        .i2c_sda_pad_oe(i2c_sda_pad_oe), .i2c_scl_pad_out(i2c_scl_pad_out), .i2c_scl_pad_oe(i2c_scl_pad_oe),
        .i2c_sda_in(i2c_sda_in), .i2c_scl_in(i2c_scl_in), .i2c_drive_type_sel(i2c_drive_type_sel),
        .i2c_drive_type(i2c_drive_type));

    // =========================================================
    // board models
    pmx_board_model #(.W(16)) bf_u (.mclk(mclk), .pad_out(portf_pad_out), .pad_oe(portf_pad_oe),
        .ext_val(fv), .ext_en(fe), .pad_in(portf_pad_in));
    pmx_board_model #(.W(16)) bg_u (.mclk(mclk), .pad_out(portg_pad_out), .pad_oe(portg_pad_oe),
        .ext_val(gv), .ext_en(ge), .pad_in(portg_pad_in));
    pmx_board_model #(.W(8)) bh_u (.mclk(mclk), .pad_out(porth_pad_out), .pad_oe(porth_pad_oe),
        .ext_val(hv), .ext_en(he), .pad_in(porth_pad_in));
    pmx_board_model #(.W(16)) bd_u (.mclk(mclk), .pad_out(ext_data_bus_out), .pad_oe({16{ext_data_bus_oe}}),
        .ext_val(dv), .ext_en(de), .pad_in(ext_data_bus_in));
    assign i2c_sda_pad_in = i2c_sda_pad_oe ? i2c_sda_pad_out : 1'b1;
    assign i2c_scl_pad_in = i2c_scl_pad_oe ? i2c_scl_pad_out : 1'b1;

    // =========================================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // =========================================================
    // scenarios
    task automatic t_reset();
        chk("sclk_hi", sdram_clock_out, 1'b1);
        #2;
        chk("sclk_lo", sdram_clock_out, 1'b0);
        chk("emi_pins", emi_pins, PMX_EMI_RESET);
        chk("emi_oe", emi_pins_oe, 1'b1);
        chk("port_oe", {portf_pad_oe, portg_pad_oe}, 32'h0);
        chk("porth_oe", porth_pad_oe, 8'h0);
        chk("xtal_rst", crystal_buffer_out, 1'b0);
        chk("gpio_in", {portf_gpio_in, portg_gpio_in}, 32'h0);
        chk("drive_type", i2c_drive_type, PMX_I2C_DT_RESET);
        $display("done t_reset");
    endtask : t_reset

    task automatic t_emi();
        emi_ctrl = 31'h5a5a1234;
        ext_data_wr = 16'hc3a5;
        ext_data_wr_en = 1'b1;
        step(1);
        chk("emi_pins", emi_pins, 31'h5a5a1234);
        chk("dbus_out", {ext_data_bus_oe, ext_data_bus_out}, 17'h1c3a5);
        ext_data_wr_en = 1'b0;
        dv = 16'h9e37;
        de = 16'hffff;
        step(3);
        chk("dbus_rd", ext_data_rd, 16'h9e37);
        $display("done t_emi");
    endtask : t_emi

    task automatic t_ppi();
        for (int i = 0; i < 16; i++)
            portf_alt[i] = '{out: 4'hf, oe: 4'hf};
        ppi_data_out = 16'hb4e1;
        ppi_data_oe = 16'hffff;
        step(1);
        chk("pf_oe_gpio", portf_pad_oe, 16'h0);
        for (int i = 0; i < 16; i++)
            portf_cfg[i].func = PMX_FN_ALT1;
        step(1);
        chk("pf_ppi", {portf_pad_oe, portf_pad_out}, 32'hffffb4e1);
        ppi_data_oe = 16'h0;
        fv = 16'h0f5a;
        fe = 16'hffff;
        step(3);
        chk("ppi_in", ppi_data_in, 16'h0f5a);
        chk("pf_gpio_idle", portf_gpio_in, 16'h0);
        chk("pf_alt_idle", portf_alt_in == '0, 1'b1);
        for (int i = 0; i < 16; i++)
            portf_cfg[i] = '{func: PMX_FN_GPIO, gpio_out: 1'b1, gpio_dir: 1'b0, gpio_ien: 1'b0};
        step(1);
        chk("pf_back_oe", portf_pad_oe, 16'h0);
        for (int i = 0; i < 16; i++)
            portf_cfg[i].gpio_dir = 1'b1;
        step(1);
        chk("pf_gpio_drv", {portf_pad_oe, portf_pad_out}, 32'hffffffff);
        $display("done t_ppi");
    endtask : t_ppi

    task automatic t_ports();
        gv = 16'ha5c3;
        ge = 16'hffff;
        step(3);
        chk("pg_buf_off", portg_gpio_in, 16'h0);
        for (int i = 0; i < 16; i++)
            portg_cfg[i].gpio_ien = 1'b1;
        step(3);
        chk("pg_buf_on", portg_gpio_in, 16'ha5c3);
        portg_cfg[PMX_AMS2_PIN].func = PMX_FN_ALT1;
        portg_cfg[PMX_AMS3_PIN].func = PMX_FN_ALT2;
        async_bank_select_hi = 2'b10;
        porth_cfg[PMX_AOE_PIN].func = PMX_FN_ALT1;
        porth_cfg[PMX_ASYNC_READY_INPUT_PIN].func = PMX_FN_ALT1;
        async_output_enable = 1'b1;
        hv = 8'h20;
        he = 8'h20;
        step(3);
        chk("bank_pins", {portg_pad_oe[15], portg_pad_oe[11], portg_pad_out[15], portg_pad_out[11]}, 4'he);
        chk("aoe_pin", {porth_pad_oe[4], porth_pad_out[4]}, 2'h3);
        chk("async_ready_input_in", async_ready_input, 1'b1);
        chk("bank_alt_in", portg_alt_in[PMX_AMS3_PIN], 4'h4);
        chk("aoe_alt_in", porth_alt_in[PMX_AOE_PIN], 4'h2);
        chk("ph_buf_off", porth_gpio_in, 8'h0);
        $display("done t_ports");
    endtask : t_ports

    task automatic t_i2c();
        for (int c = 0; c < 8; c++)
        begin
            i2c_drive_type_sel = 3'(c);
            step(1);
            chk("drive_type", i2c_drive_type, (c == 7) ? PMX_I2C_DT_MAX : 3'(c));
        end
        i2c_sda_pull_low = 1'b1;
        step(3);
        chk("sda_pull", {i2c_sda_pad_oe, i2c_sda_pad_out, i2c_sda_in, i2c_scl_in}, 4'h9);
        i2c_sda_pull_low = 1'b0;
        i2c_scl_pull_low = 1'b1;
        step(3);
        chk("sda_rel", {i2c_sda_pad_oe, i2c_sda_in}, 2'h1);
        chk("scl_pull", {i2c_scl_pad_oe, i2c_scl_pad_out, i2c_scl_in}, 3'h4);
        $display("done t_i2c");
    endtask : t_i2c

    task automatic t_hib();
        xtal_in = 1'b1;
        i2c_sda_pull_low = 1'b1;
        hibernate = 1'b1;
        step(2);
        chk("hib_oe", {emi_pins_oe, sdram_clock_out_oe, i2c_sda_pad_oe, i2c_scl_pad_oe, ext_data_bus_oe}, 5'h0);
        chk("hib_ports", {portf_pad_oe, portg_pad_oe}, 32'h0);
        chk("hib_porth", porth_pad_oe, 8'h0);
        chk("hib_xtal", crystal_buffer_out, 1'b1);
        hibernate = 1'b0;
        step(2);
        chk("wake_emi_oe", emi_pins_oe, 1'b1);
        $display("done t_hib");
    endtask : t_hib

    // =========================================================
    // clock, watchdog and main sequence
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        #4000;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        {hibernate, xtal_in, emi_ctrl, ext_data_wr, ext_data_wr_en, async_bank_select_hi, async_output_enable,
            ppi_data_out, ppi_data_oe, portf_cfg, portg_cfg, porth_cfg, portf_alt, portg_alt, porth_alt,
            i2c_sda_pull_low, i2c_scl_pull_low, i2c_drive_type_sel, fv, fe, gv, ge, hv, he, dv, de} = '0;
        resetn = 1'b0;
        step(9);
        t_reset();
        step(1);
        resetn = 1'b1;
        t_emi();
        t_ppi();
        t_ports();
        t_i2c();
        t_hib();
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
